// >>> src/uitc_defines.svh
// Register map, field positions, reset values and packet codes of the IN endpoint transmit control
`ifndef UITC_DEFINES_SVH
`define UITC_DEFINES_SVH

// Register indices; byte address is four times the index
`define UITC_IDX_FLAGS    7'h11
`define UITC_IDX_CFG      7'h13
`define UITC_IDX_EP0_SET  7'h14
`define UITC_IDX_EP1_SET  7'h15
`define UITC_IDX_EP2_SET  7'h16
`define UITC_IDX_MASK     7'h20
`define UITC_IDX_BUF_LO   7'h50
`define UITC_IDX_BUF_HI   7'h67

// Interrupt flag bits
`define UITC_FLG_EP0_DONE 5
`define UITC_FLG_EPA_DONE 4
`define UITC_FLG_EPB_DONE 3
`define UITC_FLG_EP0_BIT  5
`define UITC_FLG_USED     8'h38

// Endpoint configuration bits
`define UITC_CFG_EPA_EN   5
`define UITC_CFG_EPB_EN   4
`define UITC_CFG_WMASK    8'hF9

// Setup register fields
`define UITC_SET_ARMED    7
`define UITC_SET_PID_SEL  6
`define UITC_SET_HALT     5
`define UITC_SET_IN_HALT  4
`define UITC_SET_LEN_MSB  3
`define UITC_SET_WMASK0   8'hFF
`define UITC_SET_WMASK12  8'hEF
`define UITC_MAX_LEN      4'h8

// Reset values
`define UITC_RST_REG      8'h00

// Token and packet identifiers on the link
`define UITC_TOK_IN       4'h9
`define UITC_TOK_OUT      4'h1
`define UITC_PID_DATA0    8'hC3
`define UITC_PID_DATA1    8'h4B
`define UITC_PID_NAK      8'h5A
`define UITC_PID_STALL    8'h1E

`endif

// >>> src/uitc_pkg.sv
// Types shared by the IN endpoint transmit control
package uitc_pkg;
	typedef logic [7:0] uitc_byte_t;
	typedef enum logic [2:0] {S_IDLE, S_PID, S_FETCH, S_DATA, S_WAIT_ACK} uitc_state_t;
endpackage

// >>> src/uitc_buf_mem.sv
// Transmit buffer store: one write port, two registered read ports
`timescale 1ns/1ps
module uitc_buf_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 24,
	parameter int AW    = 5
) (
	// Clock
	input  wire logic             clk_i,
	// Write port
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	// Read ports
	input  wire logic [AW-1:0]    a_addr_i,
	output logic      [WIDTH-1:0] a_data_o,
	input  wire logic [AW-1:0]    b_addr_i,
	output logic      [WIDTH-1:0] b_data_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i)
	begin
		if (wr_en_i)
		begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		a_data_o <= mem[a_addr_i];
		b_data_o <= mem[b_addr_i];
	end
endmodule

// >>> src/uitc_tx_ctrl.sv
// IN endpoint transmit control for the control endpoint and two interrupt endpoints
// How it works
// RULE_01: IN on endpoint 0 sends its buffer only when armed and not halted.
// RULE_02: Endpoint 0 sends exactly its length field bytes, never above eight.
// RULE_03: Endpoint 0 pid select bit picks DATA0 or DATA1.
// RULE_04: Firmware arms endpoint 0 only after its buffer is loaded.
// RULE_05: Host ack on endpoint 0 disarms it and sets its done flag.
// RULE_06: Done flags stay set until firmware writes a one to clear.
// RULE_07: Endpoint 0 halt answers IN and OUT tokens with STALL.
// RULE_08: Endpoints 1 and 2 are IN only and work only while enabled.
// RULE_09: IN on endpoint 1 or 2 sends its own buffer when armed, unhalted.
// RULE_10: Endpoints 1 and 2 send their length field bytes, at most eight.
// RULE_11: Endpoints 1 and 2 pid select bit picks DATA0 or DATA1.
// RULE_12: Host ack on endpoint 1 or 2 disarms it and sets its done flag.
// RULE_13: Halt on endpoint 1 or 2 answers its tokens with STALL.
// RULE_14: Firmware arms endpoint 1 or 2 only after filling its buffer.
// RULE_15: Firmware may read the armed bit to confirm completion.
// RULE_16: Enabled unhalted endpoint not armed answers NAK and changes nothing.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "uitc_defines.svh"
module uitc_tx_ctrl (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Register bus
	input  wire logic [6:0]        address_i,
	input  wire logic              read_i,
	input  wire logic              write_i,
	input  wire logic [3:0]        byteenable_i,
	input  wire logic [31:0]       writedata_i,
	output logic      [31:0]       readdata_o,
	output logic                   waitrequest_o,
	// Token side
	input  wire logic              token_valid_i,
	input  wire logic [3:0]        token_pid_i,
	input  wire logic [3:0]        token_ep_i,
	input  wire logic              host_ack_i,
	// Packet byte stream
	output logic                   tx_valid_o,
	output uitc_pkg::uitc_byte_t   tx_data_o,
	output logic                   tx_last_o,
	input  wire logic              tx_ready_i,
	// Interrupt
	output logic                   irq_o
);
	import uitc_pkg::*;

	uitc_state_t st;
	uitc_byte_t  setup [3];
	uitc_byte_t  cfg;
	uitc_byte_t  flags;
	uitc_byte_t  mask;
	logic        rd_stage;
	logic [1:0]  cur_ep;
	logic [3:0]  cur_len;
	logic [3:0]  idx;
	logic        cur_data;
	uitc_byte_t  mem_a_q;
	uitc_byte_t  mem_b_q;

	// Bus decode
	logic       wr_fire;
	logic       in_buf;
	logic [4:0] buf_addr;
	uitc_byte_t wdata;
	uitc_byte_t rd_mux;
	uitc_byte_t clr_vec;
	uitc_byte_t done_set;

	assign wr_fire  = write_i && !waitrequest_o && byteenable_i[0];
	assign in_buf   = address_i >= `UITC_IDX_BUF_LO && address_i <= `UITC_IDX_BUF_HI;
	assign buf_addr = 5'(address_i - `UITC_IDX_BUF_LO);
	assign wdata    = writedata_i[7:0];
	assign clr_vec  = (wr_fire && address_i == `UITC_IDX_FLAGS) ? (wdata & `UITC_FLG_USED) : 8'h00;

	// Token decode
	logic       tok_in;
	logic       tok_out;
	logic [1:0] sel;
	logic       ep_ok;
	logic       halted;
	logic       armed;
	logic       pid_sel_now;
	logic [3:0] len_eff;
	logic       resp_valid;
	logic       resp_data;
	uitc_byte_t resp_pid;
	logic       tok_open;
	logic       start;
	logic       ack_evt;

	assign tok_in      = token_pid_i == `UITC_TOK_IN;
	assign tok_out     = token_pid_i == `UITC_TOK_OUT;
	assign sel         = (token_ep_i < 4'h3) ? token_ep_i[1:0] : 2'h0;
	assign pid_sel_now = setup[sel][`UITC_SET_PID_SEL];
	assign armed       = setup[sel][`UITC_SET_ARMED];
	assign len_eff     = (setup[sel][`UITC_SET_LEN_MSB:0] > `UITC_MAX_LEN) ? `UITC_MAX_LEN
	                     : setup[sel][`UITC_SET_LEN_MSB:0]; // RULE_02 RULE_10

	always_comb
	begin
		ep_ok = 1'b0;
		unique case (token_ep_i)
			4'h0: ep_ok = 1'b1;
			4'h1: ep_ok = cfg[`UITC_CFG_EPA_EN]; // RULE_08
			4'h2: ep_ok = cfg[`UITC_CFG_EPB_EN]; // RULE_08
			default: ep_ok = 1'b0;
		endcase
	end

	// Endpoint 0 also honours its IN-only halt bit
	assign halted = setup[sel][`UITC_SET_HALT] || (sel == 2'h0 && setup[0][`UITC_SET_IN_HALT]); // RULE_07 RULE_13

	always_comb
	begin
		resp_valid = 1'b0;
		resp_data  = 1'b0;
		resp_pid   = `UITC_PID_NAK;
		if (tok_in && ep_ok)
		begin
			resp_valid = 1'b1;
			if (halted)
			begin
				resp_pid = `UITC_PID_STALL; // RULE_07 RULE_13
			end
			else if (armed)
			begin
				resp_data = 1'b1; // RULE_01 RULE_09
				resp_pid  = pid_sel_now ? `UITC_PID_DATA1 : `UITC_PID_DATA0; // RULE_03 RULE_11
			end
			else
			begin
				resp_pid = `UITC_PID_NAK; // RULE_16
			end
		end
		else if (tok_out && token_ep_i == 4'h0 && setup[0][`UITC_SET_HALT])
		begin
			// OUT data itself is handled elsewhere; only the stall answer lives here
			resp_valid = 1'b1;
			resp_pid   = `UITC_PID_STALL; // RULE_07
		end
	end

	// A token during the ack wait means the host dropped the ack; buffer stays armed
	assign tok_open = st == S_IDLE || (st == S_WAIT_ACK && !host_ack_i);
	assign start    = token_valid_i && tok_open && resp_valid;
	assign ack_evt  = st == S_WAIT_ACK && host_ack_i && cur_data;

	always_comb
	begin
		done_set = 8'h00;
		if (ack_evt)
		begin
			unique case (cur_ep)
				2'h0: done_set[`UITC_FLG_EP0_BIT] = 1'b1; // RULE_05
				2'h1: done_set[`UITC_FLG_EPA_DONE] = 1'b1; // RULE_12
				default: done_set[`UITC_FLG_EPB_DONE] = 1'b1; // RULE_12
			endcase
		end
	end

	uitc_buf_mem #(
		.WIDTH (8),
		.DEPTH (24),
		.AW    (5)
	) u_mem (
		.clk_i     (clk_i),
		.wr_en_i   (wr_fire && in_buf),
		.wr_addr_i (buf_addr),
		.wr_data_i (wdata),
		.a_addr_i  (buf_addr),
		.a_data_o  (mem_a_q),
		.b_addr_i  ({cur_ep, idx[2:0]}),
		.b_data_o  (mem_b_q)
	);

	always_comb
	begin
		rd_mux = 8'h00;
		if (in_buf)
		begin
			rd_mux = mem_a_q;
		end
		else
		begin
			unique case (address_i)
				`UITC_IDX_FLAGS:   rd_mux = flags;
				`UITC_IDX_CFG:     rd_mux = cfg;
				`UITC_IDX_EP0_SET: rd_mux = setup[0];
				`UITC_IDX_EP1_SET: rd_mux = setup[1];
				`UITC_IDX_EP2_SET: rd_mux = setup[2];
				`UITC_IDX_MASK:    rd_mux = mask;
				default:           rd_mux = 8'h00;
			endcase
		end
	end

	// Bus handshake: writes answer after one cycle, reads after two to let the buffer read settle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			waitrequest_o <= 1'b1;
			rd_stage      <= 1'b0;
			readdata_o    <= 32'h0000_0000;
		end
		else if (!waitrequest_o)
		begin
			waitrequest_o <= 1'b1;
			rd_stage      <= 1'b0;
		end
		else if (write_i)
		begin
			waitrequest_o <= 1'b0;
		end
		else if (read_i)
		begin
			if (rd_stage)
			begin
				waitrequest_o <= 1'b0;
				readdata_o    <= {24'h00_0000, rd_mux};
			end
			else
			begin
				rd_stage <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cfg  <= `UITC_RST_REG;
			mask <= `UITC_RST_REG;
		end
		else if (wr_fire)
		begin
			if (address_i == `UITC_IDX_CFG)
			begin
				cfg <= wdata & `UITC_CFG_WMASK;
			end
			if (address_i == `UITC_IDX_MASK)
			begin
				mask <= wdata & `UITC_FLG_USED;
			end
		end
	end

	// A firmware write to a setup register wins over the hardware disarm in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			setup[0] <= `UITC_RST_REG;
			setup[1] <= `UITC_RST_REG;
			setup[2] <= `UITC_RST_REG;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (wr_fire && address_i == 7'(`UITC_IDX_EP0_SET + i))
				begin
					setup[i] <= wdata & ((i == 0) ? `UITC_SET_WMASK0 : `UITC_SET_WMASK12);
				end
				else if (ack_evt && cur_ep == 2'(i))
				begin
					setup[i][`UITC_SET_ARMED] <= 1'b0; // RULE_05 RULE_12
				end
			end
		end
	end

	// Set beats clear so an ack in the clearing cycle is never lost
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			flags <= `UITC_RST_REG;
		end
		else
		begin
			flags <= (flags & ~clr_vec) | done_set; // RULE_06
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= |(flags & mask);
		end
	end

	// Packet sender: PID byte first, then one buffer byte per fetch
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st         <= S_IDLE;
			tx_valid_o <= 1'b0;
			tx_data_o  <= 8'h00;
			tx_last_o  <= 1'b0;
			cur_ep     <= 2'h0;
			cur_len    <= 4'h0;
			cur_data   <= 1'b0;
			idx        <= 4'h0;
		end
		else if (start)
		begin
			st         <= S_PID;
			tx_valid_o <= 1'b1;
			tx_data_o  <= resp_pid;
			tx_last_o  <= !resp_data || len_eff == 4'h0;
			cur_ep     <= sel;
			cur_len    <= len_eff;
			cur_data   <= resp_data;
			idx        <= 4'h0;
		end
		else
		begin
			unique case (st)
				S_IDLE:
				begin
					st <= S_IDLE;
				end
				S_PID:
				begin
					if (tx_ready_i)
					begin
						tx_valid_o <= 1'b0;
						if (!tx_last_o)
						begin
							st <= S_FETCH;
						end
						else
						begin
							st <= cur_data ? S_WAIT_ACK : S_IDLE;
						end
					end
				end
				S_FETCH:
				begin
					tx_valid_o <= 1'b1;
					tx_data_o  <= mem_b_q; // RULE_01 RULE_09
					tx_last_o  <= 4'(idx + 4'h1) == cur_len; // RULE_02 RULE_10
					idx        <= 4'(idx + 4'h1);
					st         <= S_DATA;
				end
				S_DATA:
				begin
					if (tx_ready_i)
					begin
						tx_valid_o <= 1'b0;
						st         <= tx_last_o ? S_WAIT_ACK : S_FETCH;
					end
				end
				S_WAIT_ACK:
				begin
					if (host_ack_i || token_valid_i)
					begin
						st <= S_IDLE;
					end
				end
			endcase
		end
	end

	// Checks
	logic [3:0] sent_cnt;
	logic [2:0] armed_vec;
	logic [2:0] ep_onehot;

	assign armed_vec = {setup[2][`UITC_SET_ARMED], setup[1][`UITC_SET_ARMED], setup[0][`UITC_SET_ARMED]};
	assign ep_onehot = 3'(3'h1 << cur_ep);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || start)
		begin
			sent_cnt <= 4'h0;
		end
		else if (st == S_DATA && tx_ready_i)
		begin
			sent_cnt <= 4'(sent_cnt + 4'h1);
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_in_tok(int e);
		token_valid_i && tok_open && tok_in && token_ep_i == e;
	endsequence

	sequence s_launch_data;
		start && resp_data;
	endsequence

	a_ep0_in_stall: assert property (s_in_tok(0) ##0 setup[0][`UITC_SET_HALT] |=> // RULE_07
		tx_valid_o && tx_last_o && tx_data_o == `UITC_PID_STALL && st == S_PID)
		else $error("endpoint 0 halted IN not stalled");

	a_ep0_out_stall: assert property (token_valid_i && tok_open && tok_out && token_ep_i == 4'h0 // RULE_07
		&& setup[0][`UITC_SET_HALT] |=> tx_valid_o && tx_data_o == `UITC_PID_STALL)
		else $error("endpoint 0 halted OUT not stalled");

	a_epa_halt: assert property (s_in_tok(1) ##0 cfg[`UITC_CFG_EPA_EN] && setup[1][`UITC_SET_HALT] |=> // RULE_13
		tx_data_o == `UITC_PID_STALL ##1 !ack_evt)
		else $error("endpoint 1 halted IN not stalled");

	a_nak_idle: assert property (s_in_tok(2) ##0 cfg[`UITC_CFG_EPB_EN] && !setup[2][`UITC_SET_HALT] // RULE_16
		&& !setup[2][`UITC_SET_ARMED] && !wr_fire |=> tx_data_o == `UITC_PID_NAK && $stable(flags))
		else $error("unarmed endpoint did not NAK cleanly");

	a_pid_select: assert property (s_launch_data |=> // RULE_03 RULE_11
		tx_data_o == ($past(pid_sel_now) ? `UITC_PID_DATA1 : `UITC_PID_DATA0))
		else $error("data pid does not follow select bit");

	a_disabled_quiet: assert property (s_in_tok(1) ##0 !cfg[`UITC_CFG_EPA_EN] |=> // RULE_08
		!tx_valid_o && st == S_IDLE)
		else $error("disabled endpoint answered");

	a_ack_done: assert property (ack_evt |=> (flags & $past(done_set)) == $past(done_set) // RULE_05 RULE_12
		&& $past(done_set) != 8'h00)
		else $error("ack did not set done flag");

	a_ack_disarm: assert property (ack_evt && !wr_fire |=> (armed_vec & $past(ep_onehot)) == 3'h0) // RULE_05 RULE_12
		else $error("ack did not disarm endpoint");

	a_flag_sticky: assert property (1'b1 |=> // RULE_06
		(flags & $past(flags & ~clr_vec)) == $past(flags & ~clr_vec))
		else $error("done flag dropped without write");

	a_len_exact: assert property (st == S_DATA && tx_ready_i && tx_last_o |-> // RULE_02 RULE_10
		4'(sent_cnt + 4'h1) == cur_len && cur_len <= `UITC_MAX_LEN)
		else $error("byte count differs from length field");

	a_zero_len: assert property (st == S_PID && tx_ready_i && tx_last_o && cur_data |-> // RULE_02 RULE_10
		cur_len == 4'h0 ##1 st == S_WAIT_ACK)
		else $error("zero length packet mishandled");

	a_data_follows: assert property (s_launch_data ##1 (st == S_PID && tx_ready_i && !tx_last_o) |=> // RULE_01 RULE_09
		st == S_FETCH ##1 tx_valid_o && st == S_DATA)
		else $error("data byte not presented after pid");
endmodule

// >>> testbench/uitc_host_model.sv
// Behavioural USB host: issues tokens, sinks packet bytes, acknowledges data packets
`timescale 1ns/1ps
`include "uitc_defines.svh"
module uitc_host_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Bench commands
	input  wire logic       go_i,
	input  wire logic [3:0] pid_i,
	input  wire logic [3:0] ep_i,
	input  wire logic       slow_i,
	// Token side
	output logic            token_valid_o,
	output logic      [3:0] token_pid_o,
	output logic      [3:0] token_ep_o,
	output logic            host_ack_o,
	// Packet byte stream
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o,
	// Capture
	output logic            done_o,
	output logic      [4:0] count_o
);
	logic [7:0] pkt [0:15];
	logic [7:0] first;
	assign first = (count_o == 5'h00) ? tx_data_i : pkt[0];
	initial
	begin
		token_valid_o = 1'b0;
		token_pid_o = 4'h0;
		token_ep_o = 4'h0;
		host_ack_o = 1'b0;
		tx_ready_o = 1'b0;
		done_o = 1'b0;
		count_o = 5'h00;
	end
	always @(posedge clk_i)
	begin
		token_valid_o <= 1'b0;
		host_ack_o <= 1'b0;
		// Idle token fields churn so a stale value is never trusted
		token_pid_o <= ~token_pid_o;
		token_ep_o <= ~token_ep_o;
		tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
		if (!rst_n_i)
		begin
			tx_ready_o <= 1'b0;
			done_o <= 1'b0;
			count_o <= 5'h00;
		end
		else if (go_i)
		begin
			token_valid_o <= 1'b1;
			token_pid_o <= pid_i;
			token_ep_o <= ep_i;
			done_o <= 1'b0;
			count_o <= 5'h00;
		end
		else if (tx_valid_i && tx_ready_o)
		begin
			pkt[count_o[3:0]] <= tx_data_i;
			count_o <= count_o + 5'h01;
			done_o <= tx_last_i;
			// Handshakes are never acknowledged, only data packets
			host_ack_o <= tx_last_i && (first == `UITC_PID_DATA0 || first == `UITC_PID_DATA1);
		end
	end
endmodule

// >>> testbench/usb_in_endpoint_tx_ctrl_bench.sv
// Self-checking bench for the IN endpoint transmit control
`timescale 1ns/1ps
`include "uitc_defines.svh"
module usb_in_endpoint_tx_ctrl_bench;
	import uitc_pkg::*;
	logic        clk_i;
	logic        rst_n_i;
	logic [6:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitreq;
	logic        token_valid;
	logic [3:0]  token_pid;
	logic [3:0]  token_ep;
	logic        host_ack;
	logic        tx_valid;
	uitc_byte_t  tx_data;
	logic        tx_last;
	logic        tx_ready;
	logic        irq;
	logic        go;
	logic [3:0]  pid;
	logic [3:0]  ep;
	logic        slow;
	logic        h_done;
	logic [4:0]  h_count;
	int          err_total;
	int          compares;
	uitc_tx_ctrl dut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.address_i(address),
		.read_i(read),
		.write_i(write),
		.byteenable_i(4'h1),
		.writedata_i(writedata),
		.readdata_o(readdata),
		.waitrequest_o(waitreq),
		.token_valid_i(token_valid),
		.token_pid_i(token_pid),
		.token_ep_i(token_ep),
		.host_ack_i(host_ack),
		.tx_valid_o(tx_valid),
		.tx_data_o(tx_data),
		.tx_last_o(tx_last),
		.tx_ready_i(tx_ready),
		.irq_o(irq)
	);
	uitc_host_model host (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.go_i(go),
		.pid_i(pid),
		.ep_i(ep),
		.slow_i(slow),
		.token_valid_o(token_valid),
		.token_pid_o(token_pid),
		.token_ep_o(token_ep),
		.host_ack_o(host_ack),
		.tx_valid_i(tx_valid),
		.tx_data_i(tx_data),
		.tx_last_i(tx_last),
		.tx_ready_o(tx_ready),
		.done_o(h_done),
		.count_o(h_count)
	);
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic tally_and_finish;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk_i);
		address <= a;
		writedata <= {24'h000000, d};
		write <= wr;
		read <= ~wr;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 50)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk({24'h000000, q}, {24'h000000, exp});
	endtask
	// Waits for the whole packet plus the ack and irq lag when an answer is due
	task automatic xfer(input logic [3:0] p, input logic [3:0] e, input logic answer);
		int n;
		@(posedge clk_i);
		go <= 1'b1;
		pid <= p;
		ep <= e;
		@(posedge clk_i);
		go <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (answer && h_done !== 1'b1 && n < 300);
		if (n >= 300)
		begin
			err_total++;
			tally_and_finish();
		end
		repeat (6) @(posedge clk_i);
		if (!answer)
			chk({27'h0, h_count}, 32'h0);
	endtask
	task automatic chk_pkt(input logic [7:0] p, input int e, input int len);
		chk({27'h0, h_count}, len + 1);
		chk({24'h0, host.pkt[0]}, {24'h0, p});
		for (int k = 0; k < len; k++)
			chk({24'h0, host.pkt[k + 1]}, 32'hA0 + 32'h10 * e + k);
	endtask
	initial
	begin
		logic [7:0] s;
		logic [6:0] idx [6];
		err_total = 0;
		compares = 0;
		rst_n_i = 1'b0;
		address = 7'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		go = 1'b0;
		pid = 4'h0;
		ep = 4'h0;
		slow = 1'b0;
		idx = '{7'h11, 7'h13, 7'h14, 7'h15, 7'h16, 7'h20};
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (idx[i])
			rd(idx[i], 8'h00);
		chk({31'h0, irq}, 32'h0);
		wr(7'h30, 8'h5A);
		rd(7'h30, 8'h00);
		$display("test reset done");
		// Buffers are filled before any endpoint is armed
		for (int e = 0; e < 3; e++)
			for (int k = 0; k < 8; k++)
				wr(7'(32'h50 + 8 * e + k), 8'(32'hA0 + 32'h10 * e + k));
		wr(7'h13, 8'h30);
		wr(7'h20, 8'h38);
		rd(7'h13, 8'h30);
		xfer(`UITC_TOK_IN, 4'h0, 1'b1);
		chk_pkt(`UITC_PID_NAK, 0, 0);
		rd(7'h11, 8'h00);
		$display("test nak done");
		for (int e = 0; e < 3; e++)
		begin
			s = (e == 0) ? 8'hC8 : (e == 1) ? 8'h83 : 8'hCF;
			slow <= (e == 2);
			wr(7'(32'h14 + e), s);
			xfer(`UITC_TOK_IN, 4'(e), 1'b1);
			chk_pkt(s[6] ? `UITC_PID_DATA1 : `UITC_PID_DATA0, e, (e == 1) ? 3 : 8);
			rd(7'(32'h14 + e), s & 8'h7F);
			wr(7'h11, 8'h00);
			rd(7'h11, 8'h20 >> e);
			chk({31'h0, irq}, 32'h1);
			wr(7'h20, 8'h00);
			repeat (2) @(posedge clk_i);
			chk({31'h0, irq}, 32'h0);
			wr(7'h20, 8'h38);
			wr(7'h11, 8'h20 >> e);
			rd(7'h11, 8'h00);
			chk({31'h0, irq}, 32'h0);
		end
		slow <= 1'b0;
		$display("test data done");
		for (int e = 0; e < 3; e++)
		begin
			wr(7'(32'h14 + e), 8'hA1);
			xfer(`UITC_TOK_IN, 4'(e), 1'b1);
			chk_pkt(`UITC_PID_STALL, e, 0);
			rd(7'(32'h14 + e), 8'hA1);
		end
		xfer(`UITC_TOK_OUT, 4'h0, 1'b1);
		chk_pkt(`UITC_PID_STALL, 0, 0);
		rd(7'h11, 8'h00);
		wr(7'h14, 8'h91);
		xfer(`UITC_TOK_IN, 4'h0, 1'b1);
		chk_pkt(`UITC_PID_STALL, 0, 0);
		rd(7'h14, 8'h91);
		wr(7'h14, 8'h00);
		$display("test stall done");
		wr(7'h13, 8'h00);
		wr(7'h15, 8'h81);
		xfer(`UITC_TOK_IN, 4'h1, 1'b0);
		wr(7'h13, 8'h30);
		xfer(`UITC_TOK_OUT, 4'h1, 1'b0);
		xfer(`UITC_TOK_IN, 4'h3, 1'b0);
		xfer(`UITC_TOK_IN, 4'h1, 1'b1);
		chk_pkt(`UITC_PID_DATA0, 1, 1);
		$display("test enable done");
		tally_and_finish();
	end
endmodule
